// file: hw/mss_pkg.sv
// constants, types and timing for the motor shutdown and stall supervisor
package mss_pkg;
	// clock and persistence timebase
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_HZ = 1000;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int PERSIST_S = 15;
	localparam int PERSIST_TICKS = PERSIST_S * TICK_HZ;
	// stabilisation wait before a second phase, value chosen here
	localparam int TSTAB_US = 1000;
	localparam int TSTAB_CYCLES = TSTAB_US * (CLK_HZ / 1_000_000);
	// stall detector layout
	localparam int THR_W = 4;
	localparam int DLY_W = 3;
	localparam int AVG_SHIFT = 3;
	localparam int ABS_SHIFT = 3;
	localparam int DEL_SHIFT = 2;

	typedef enum logic [3:0] {
		MSS_HOLD = 4'h1,
		MSS_MOVE = 4'h2,
		MSS_STAB = 4'h4,
		MSS_SHUT = 4'h8
	} mss_state_e;

	typedef struct packed {
		logic thermalWarning;
		logic thermal;
		logic batLow;
		logic cpLow;
		logic coilDefect;
	} mss_fault_s;

	typedef struct packed {
		logic atMaxVelocity;
		logic fullStep;
		logic motionDone;
		logic firstPhase;
		logic autarkic;
		logic fullDuty;
	} mss_motion_s;

	typedef struct packed {
		logic [THR_W-1:0] absoluteThreshold;
		logic [THR_W-1:0] deltaThreshold;
		logic [DLY_W-1:0] detectStartDelay;
		logic fullDutyDetectEnable;
	} mss_stall_cfg_s;

	typedef struct packed {
		logic thermalWarningFlag;
		logic tempShutFlag;
		logic batteryLowLevelTwo;
		logic coilDefectFlag;
		logic cpFailFlag;
		logic stepLoss;
		logic stall;
		logic absStall;
		logic delStallLo;
		logic delStallHi;
	} mss_flags_s;

	localparam int SYNC_W = $bits(mss_fault_s);
	localparam int FLAG_W = $bits(mss_flags_s);
endpackage : mss_pkg

// file: hw/mss_persist.sv
// persistence timer: level must hold for a count of divided ticks
`timescale 1ns/1ps
`default_nettype none
module mss_persist
#(
	parameter int TICKS = mss_pkg::PERSIST_TICKS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// divided timebase and monitored level
	input wire logic tick,
	input wire logic cond,
	// level has lasted past the limit
	output logic expired
);
	import mss_pkg::*;
	localparam int CW = $clog2(TICKS + 1);

	if (TICKS < 1)
	begin : g_chk
		$error("persistence limit must be at least one tick");
	end

	logic [CW-1:0] cnt_q;
	logic expired_q;
	wire atLimit = (cnt_q == CW'(TICKS));

	// counter restarts as soon as the level drops, so glitches never add up
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			expired_q <= 1'b0;
		end
		else
		begin
			if (!cond)
				cnt_q <= '0;
			else if (tick && !atLimit)
				cnt_q <= cnt_q + 1'b1;
			expired_q <= cond && atLimit;
		end
	end

	assign expired = expired_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_PERSIST_RESTART: assert property (!cond |=> !expired && cnt_q == '0)
		else $error("persistence timer did not restart");
	AST_PERSIST_EARLY: assert property (cond && cnt_q == '0 |=> !expired [*2])
		else $error("persistence expired without counting");
endmodule : mss_persist
`default_nettype wire

// file: hw/mss_supervisor.sv
// motor shutdown supervisor with back-emf stall detection
`timescale 1ns/1ps
`default_nettype none
module mss_supervisor
#(
	parameter int BW = 8,
	parameter int PW = 16,
	parameter int TICK_DIV = mss_pkg::TICK_DIV,
	parameter int PERSIST_TICKS = mss_pkg::PERSIST_TICKS,
	parameter int TSTAB_CYCLES = mss_pkg::TSTAB_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// fault indications from analog side, asynchronous
	input wire mss_pkg::mss_fault_s faultPins,
	// host commands, one-cycle pulses
	input wire logic fullStatusReadCmd,
	input wire logic gotoPositionCmd,
	input wire logic [PW-1:0] gotoTarget,
	// motion controller status, same clock
	input wire mss_pkg::mss_motion_s motion,
	input wire logic [PW-1:0] internalPos,
	// back-emf sampler, same clock
	input wire logic bemfValid,
	input wire logic [BW-1:0] bemfSample,
	// stall detector configuration
	input wire mss_pkg::mss_stall_cfg_s stallCfg,
	// bridge and controller commands
	output logic bridgeHiZ,
	output logic holdCurrent,
	output logic motionGo,
	output logic hardStop,
	output logic phaseTwoStart,
	// positions and flags
	output logic [PW-1:0] targetPos,
	output logic [PW-1:0] actualPos,
	output var mss_pkg::mss_flags_s flags
);
	import mss_pkg::*;

	localparam int DIV_W = $clog2(TICK_DIV);
	localparam int STW = $clog2(TSTAB_CYCLES + 1);
	localparam int AW = BW + AVG_SHIFT;

	// refuse sizes the comparators or timers cannot serve
	if (BW < THR_W + ABS_SHIFT + 1 || PW < 2)
	begin : g_width_chk
		$error("bemf or position width too small");
	end
	if (TICK_DIV < 2 || TSTAB_CYCLES < 1)
	begin : g_time_chk
		$error("timing counts out of range");
	end

	// three-stage synchroniser; a change counts once stages two and three agree
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] sync3_q;
	mss_fault_s fault_q;
	wire [SYNC_W-1:0] faultAgree = (sync2_q & sync3_q) | (fault_q & (sync2_q | sync3_q));

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			fault_q <= '0;
		end
		else
		begin
			sync1_q <= faultPins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			fault_q <= faultAgree;
		end
	end

	// divided timebase for the long persistence checks
	logic [DIV_W-1:0] div_q;
	logic tick_q;
	wire divWrap = (div_q == DIV_W'(TICK_DIV - 1));

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q <= divWrap ? '0 : div_q + 1'b1;
			tick_q <= divWrap;
		end
	end

	// low battery and weak charge pump only count toward shutdown once they persist; their flags set at once
	logic uvLong;
	logic cpLong;

	mss_persist #(.TICKS(PERSIST_TICKS)) u_uvPersist (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick_q),
		.cond(fault_q.batLow),
		.expired(uvLong)
	);

	mss_persist #(.TICKS(PERSIST_TICKS)) u_cpPersist (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick_q),
		.cond(fault_q.cpLow),
		.expired(cpLong)
	);

	// any of the four causes holds the motor in shutdown
	wire shutCause = fault_q.thermal | uvLong | cpLong | fault_q.coilDefect;

	// state, timers and registered outputs
	mss_state_e state_q;
	mss_state_e state_d;
	logic [STW-1:0] stab_q;
	logic [DLY_W-1:0] fsCnt_q;
	logic [AW-1:0] acc_q;
	logic bridgeHiZ_q;
	logic holdCurrent_q;
	logic motionGo_q;
	logic hardStop_q;
	logic phaseTwo_q;
	logic [PW-1:0] targetPos_q;
	logic [PW-1:0] actualPos_q;
	mss_flags_s flags_q;

	// moving average as an exponential filter over 2**AVG_SHIFT samples
	wire [BW-1:0] avg = acc_q[AW-1:AVG_SHIFT];
	wire [AW-1:0] accNext = acc_q - AW'(avg) + AW'(bemfSample);

	// threshold levels in sample units; one spare bit keeps sums from wrapping
	wire [BW:0] absLvl = (BW+1)'(stallCfg.absoluteThreshold) << ABS_SHIFT;
	wire [BW:0] delLvl = (BW+1)'(stallCfg.deltaThreshold) << DEL_SHIFT;
	wire [BW:0] sampleX = {1'b0, bemfSample};
	wire [BW:0] avgX = {1'b0, avg};
	wire absOn = |stallCfg.absoluteThreshold;
	wire delOn = |stallCfg.deltaThreshold;
	wire detectOn = absOn || delOn;

	// arming waits for top speed plus the programmed full steps
	wire delayDone = (fsCnt_q >= stallCfg.detectStartDelay);
	wire dutyOk = stallCfg.fullDutyDetectEnable || !motion.fullDuty;
	wire armed = detectOn && motion.atMaxVelocity && delayDone && dutyOk
		&& (state_q == MSS_MOVE);
	wire evalNow = armed && bemfValid;
	wire evHi = evalNow && delOn && (sampleX > avgX + delLvl);
	wire evLo = evalNow && delOn && (sampleX + delLvl < avgX);
	wire evAbs = evalNow && absOn && (sampleX < absLvl);
	wire stallEv = evHi | evLo | evAbs;

	// decoded transitions
	wire stabDone = (stab_q == STW'(TSTAB_CYCLES - 1));
	wire enterShut = (state_d == MSS_SHUT) && (state_q != MSS_SHUT);
	wire inShut = (state_q == MSS_SHUT);
	wire cpDuringMove = fault_q.cpLow && (state_q == MSS_MOVE);

	// next state; a live cause overrides every other transition
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			MSS_HOLD:
				if (gotoPositionCmd)
					state_d = MSS_MOVE;
			MSS_MOVE:
				if (stallEv)
					state_d = motion.firstPhase ? MSS_STAB : MSS_HOLD;
				else if (motion.motionDone)
					state_d = MSS_HOLD;
			MSS_STAB:
				if (stabDone)
					state_d = MSS_MOVE;
			MSS_SHUT:
				if (fullStatusReadCmd && !shutCause)
					state_d = MSS_HOLD;
			default:
				state_d = MSS_SHUT;
		endcase
		if (shutCause)
			state_d = MSS_SHUT;
	end

	// flag set terms; hardware set wins over the read clear
	mss_flags_s flagSet;
	assign flagSet.thermalWarningFlag = fault_q.thermalWarning;
	assign flagSet.tempShutFlag = fault_q.thermal;
	assign flagSet.batteryLowLevelTwo = fault_q.batLow;
	assign flagSet.coilDefectFlag = fault_q.coilDefect;
	assign flagSet.cpFailFlag = fault_q.cpLow;
	assign flagSet.stepLoss = (stallEv | cpDuringMove) && !inShut;
	assign flagSet.stall = stallEv;
	assign flagSet.absStall = evAbs;
	assign flagSet.delStallLo = evLo;
	assign flagSet.delStallHi = evHi;
	wire [FLAG_W-1:0] flagKeep = flags_q & ~{FLAG_W{fullStatusReadCmd}};
	wire [FLAG_W-1:0] flags_d = flagKeep | flagSet;

	// state and timers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= MSS_HOLD;
			stab_q <= '0;
			fsCnt_q <= '0;
			acc_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			stab_q <= (state_q == MSS_STAB) ? stab_q + 1'b1 : '0;
			if (!motion.atMaxVelocity)
				fsCnt_q <= '0;
			else if (motion.fullStep && !delayDone)
				fsCnt_q <= fsCnt_q + 1'b1;
			if (bemfValid)
				acc_q <= accNext;
		end
	end

	// bridge drive and command pulses
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bridgeHiZ_q <= 1'b0;
			holdCurrent_q <= 1'b1;
			motionGo_q <= 1'b0;
			hardStop_q <= 1'b0;
			phaseTwo_q <= 1'b0;
		end
		else
		begin
			bridgeHiZ_q <= (state_d == MSS_SHUT);
			holdCurrent_q <= (state_d == MSS_HOLD);
			motionGo_q <= gotoPositionCmd && (state_d == MSS_MOVE);
			hardStop_q <= stallEv;
			phaseTwo_q <= (state_q == MSS_STAB) && (state_d == MSS_MOVE);
		end
	end

	// positions; shutdown copy takes priority over a set-point in the same cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			targetPos_q <= '0;
			actualPos_q <= '0;
			flags_q <= '0;
		end
		else
		begin
			if (enterShut && !motion.autarkic)
				targetPos_q <= actualPos_q;
			else if (gotoPositionCmd)
				targetPos_q <= gotoTarget;
			if (stallEv || !flags_q.stall)
				actualPos_q <= internalPos;
			flags_q <= mss_flags_s'(flags_d);
		end
	end

	assign bridgeHiZ = bridgeHiZ_q;
	assign holdCurrent = holdCurrent_q;
	assign motionGo = motionGo_q;
	assign hardStop = hardStop_q;
	assign phaseTwoStart = phaseTwo_q;
	assign targetPos = targetPos_q;
	assign actualPos = actualPos_q;
	assign flags = flags_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_TEMP_SHUT: assert property (fault_q.thermal |=> state_q == MSS_SHUT)
		else $error("over-temperature did not shut down");
	AST_UV_SHUT: assert property (uvLong |=> bridgeHiZ_q)
		else $error("long battery low did not open bridges");
	AST_CP_SHUT: assert property (cpLong |=> state_q == MSS_SHUT)
		else $error("long charge pump failure did not shut down");
	AST_COIL_SHUT: assert property (fault_q.coilDefect |=> bridgeHiZ_q)
		else $error("coil defect did not shut down");
	AST_SHUT_HIZ: assert property ((state_q == MSS_SHUT) == bridgeHiZ_q)
		else $error("bridge state disagrees with shutdown");
	AST_TAG_COPY: assert property ($rose(bridgeHiZ_q) && !$past(motion.autarkic)
		|-> targetPos_q == $past(actualPos_q))
		else $error("target not loaded from actual on shutdown");
	AST_STAY_SHUT: assert property (inShut && (!fullStatusReadCmd || shutCause)
		|=> state_q == MSS_SHUT)
		else $error("shutdown left without read or with cause");
	AST_HOLD_AFTER: assert property ($fell(bridgeHiZ_q) |-> holdCurrent_q)
		else $error("no hold current after shutdown");
	AST_NO_MOTION: assert property (inShut |-> !motionGo_q)
		else $error("motion started during shutdown");
	AST_FLAG_CLR: assert property (fullStatusReadCmd && !fault_q.thermal
		|=> !flags_q.tempShutFlag)
		else $error("temperature flag not cleared by read");
	AST_STALL_OR: assert property (flags_q.stall
		== (flags_q.absStall | flags_q.delStallLo | flags_q.delStallHi))
		else $error("stall flag is not the OR of its parts");
	AST_MAX_VEL: assert property (!motion.atMaxVelocity && !flags_q.stall
		|=> !flags_q.stall)
		else $error("stall raised outside maximum velocity");
	AST_STALL_STOP: assert property (stallEv |=> hardStop_q && flags_q.stepLoss
		&& actualPos_q == $past(internalPos))
		else $error("stall without hard stop, step loss or position copy");
	AST_PHASE_TWO: assert property (stallEv && motion.firstPhase && !shutCause
		|=> state_q == MSS_STAB)
		else $error("first-phase stall did not wait for stabilisation");
	AST_NO_LOSS_SHUT: assert property (inShut && !flags_q.stepLoss
		|=> !flags_q.stepLoss)
		else $error("step loss flagged during shutdown");
	AST_DETECT_OFF: assert property (!detectOn && !flags_q.stall |=> !flags_q.stall)
		else $error("stall raised with detection disabled");

	// each detector sets its own flag, flags hold until read, position tracks when clear
	AST_HI_FLAG: assert property (evHi |=> flags_q.delStallHi && flags_q.stall)
		else $error("high delta stall not flagged");
	AST_LO_FLAG: assert property (evLo |=> flags_q.delStallLo && flags_q.stall)
		else $error("low delta stall not flagged");
	AST_ABS_FLAG: assert property (evAbs |=> flags_q.absStall && flags_q.stall)
		else $error("absolute stall not flagged");
	AST_STICKY: assert property (flags_q.stall && !fullStatusReadCmd
		|=> flags_q.stall)
		else $error("stall flag dropped without a read");
	AST_CLR_ALL: assert property (fullStatusReadCmd && flagSet == '0
		|=> flags_q == '0)
		else $error("status read left a flag without cause");
	AST_TRACK: assert property (!flags_q.stall && !stallEv
		|=> actualPos_q == $past(internalPos))
		else $error("actual position stopped tracking");
	AST_STAB_NOGO: assert property (state_q == MSS_STAB
		|-> !motionGo_q && !holdCurrent_q)
		else $error("motion or hold during stabilisation");
endmodule : mss_supervisor
`default_nettype wire

// file: test/mss_host_model.sv
// host-side command source for the supervisor bench
`timescale 1ns/1ps
`default_nettype none
module mss_host_model
#(
	parameter int PW = 16,
	parameter int MAX_RETRY = 4
) (
	// clock and shutdown view
	input wire logic clock,
	input wire logic bridgeHiZ,
	// command pulses
	output logic fullStatusReadCmd,
	output logic gotoPositionCmd,
	output logic [PW-1:0] gotoTarget
);
	int failRun = 0;

	// idle bus at time zero
	initial
	begin
		fullStatusReadCmd = 1'b0;
		gotoPositionCmd = 1'b0;
		gotoTarget = '0;
	end

	// one-cycle goto pulse; the set-point is scrambled once released
	task automatic goto(input logic [PW-1:0] t);
		@(negedge clock);
		gotoPositionCmd = 1'b1;
		gotoTarget = t;
		@(negedge clock);
		gotoPositionCmd = 1'b0;
		gotoTarget = ~t;
	endtask : goto

	// status read; gives up after a run of reads that leave shutdown standing
	task automatic read();
		if (failRun < MAX_RETRY)
		begin
			@(negedge clock);
			fullStatusReadCmd = 1'b1;
			@(negedge clock);
			fullStatusReadCmd = 1'b0;
			failRun = bridgeHiZ ? failRun + 1 : 0;
		end
	endtask : read
endmodule : mss_host_model
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the shutdown and stall supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mss_pkg::*;
	logic clock;
	logic rst_n;
	logic bemfValid;
	logic fullStatusReadCmd;
	logic gotoPositionCmd;
	logic [15:0] gotoTarget;
	logic [15:0] internalPos;
	logic [15:0] targetPos;
	logic [15:0] actualPos;
	logic [7:0] bemfSample;
	mss_fault_s faultPins;
	mss_motion_s mot;
	mss_stall_cfg_s cfg;
	mss_flags_s flags;
	logic bridgeHiZ;
	logic holdCurrent;
	logic motionGo;
	logic hardStop;
	logic phaseTwoStart;
	int err_total = 0;
	int compares = 0;
	// flag bit per fault pin: coil, charge pump, battery, thermal
	int fb[4] = '{6, 5, 7, 8};

	// short timebase so persistence and stabilisation fit the run
	mss_supervisor #(.TICK_DIV(4), .PERSIST_TICKS(3), .TSTAB_CYCLES(5)) dut (
		.clock(clock),
		.rst_n(rst_n),
		.faultPins(faultPins),
		.fullStatusReadCmd(fullStatusReadCmd),
		.gotoPositionCmd(gotoPositionCmd),
		.gotoTarget(gotoTarget),
		.motion(mot),
		.internalPos(internalPos),
		.bemfValid(bemfValid),
		.bemfSample(bemfSample),
		.stallCfg(cfg),
		.bridgeHiZ(bridgeHiZ),
		.holdCurrent(holdCurrent),
		.motionGo(motionGo),
		.hardStop(hardStop),
		.phaseTwoStart(phaseTwoStart),
		.targetPos(targetPos),
		.actualPos(actualPos),
		.flags(flags)
	);

	mss_host_model host (
		.clock(clock),
		.bridgeHiZ(bridgeHiZ),
		.fullStatusReadCmd(fullStatusReadCmd),
		.gotoPositionCmd(gotoPositionCmd),
		.gotoTarget(gotoTarget)
	);

	// 10 MHz system clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic idle(input int k);
		repeat (k) @(negedge clock);
	endtask : idle

	// bounded wait for shutdown or for the second-phase pulse
	task automatic waitfor(input bit p2);
		int n;
		for (n = 0; n < 60; n++)
		begin
			if ((p2 ? phaseTwoStart : bridgeHiZ) === 1'b1)
				break;
			@(negedge clock);
		end
		chk("wait", 16'(n < 60), 16'h0001);
		if (n == 60)
			tally_and_finish();
	endtask : waitfor

	// one back-emf strobe; the sample line is scrambled afterwards
	task automatic samp(input logic [7:0] v);
		@(negedge clock);
		bemfValid = 1'b1;
		bemfSample = v;
		@(negedge clock);
		bemfValid = 1'b0;
		bemfSample = ~v;
	endtask : samp

	initial
	begin
		rst_n = 1'b0;
		faultPins = '0;
		mot = '0;
		cfg = '0;
		internalPos = 16'h1234;
		bemfValid = 1'b0;
		bemfSample = 8'h00;
		idle(10);
		rst_n = 1'b1;
		idle(1);
		chk("hiz0", bridgeHiZ, 1'b0);
		chk("ihold0", holdCurrent, 1'b1);
		chk("flags0", flags, 10'h000);
		$display("test reset done");
		// two short battery dips must not add up to a shutdown
		faultPins.batLow = 1'b1;
		idle(6);
		faultPins.batLow = 1'b0;
		idle(2);
		faultPins.batLow = 1'b1;
		idle(6);
		faultPins.batLow = 1'b0;
		idle(6);
		chk("hizdip", bridgeHiZ, 1'b0);
		chk("batflag", flags[7], 1'b1);
		$display("test persistence done");
		host.goto(16'h00aa);
		chk("go", motionGo, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			mot.autarkic = (i == 3);
			faultPins[i] = 1'b1;
			waitfor(1'b0);
			chk("hold", holdCurrent, 1'b0);
			chk("flag", flags[fb[i]], 1'b1);
			chk("tag", targetPos, (i == 3) ? 16'h0052 : 16'h1234);
			host.goto(16'h0050 + 16'(i));
			chk("tgt", targetPos, 16'h0050 + 16'(i));
			chk("nogo", motionGo, 1'b0);
			host.read();
			chk("stay", bridgeHiZ, 1'b1);
			chk("reflag", flags[fb[i]], 1'b1);
			chk("noloss", flags.stepLoss, 1'b0);
			faultPins[i] = 1'b0;
			idle(6);
			host.read();
			chk("out", bridgeHiZ, 1'b0);
			chk("ihold", holdCurrent, 1'b1);
			chk("clr", flags[fb[i]], 1'b0);
		end
		mot.autarkic = 1'b0;
		$display("test shutdown done");
		// absolute stall, gated first by velocity and by zero thresholds
		cfg.absoluteThreshold = 4'h2;
		cfg.deltaThreshold = 4'hf;
		host.goto(16'h2000);
		samp(8'h08);
		chk("nomax", hardStop, 1'b0);
		mot.atMaxVelocity = 1'b1;
		cfg = '0;
		samp(8'h08);
		chk("off", hardStop, 1'b0);
		cfg.absoluteThreshold = 4'h2;
		cfg.deltaThreshold = 4'hf;
		samp(8'h08);
		chk("stop", hardStop, 1'b1);
		chk("abs", flags[4:0], 5'b11100);
		chk("act", actualPos, 16'h1234);
		internalPos = 16'h1300;
		idle(3);
		chk("keep", flags[4:0], 5'b11100);
		host.read();
		chk("sclr", flags[4:0], 5'b00000);
		idle(1);
		chk("track", actualPos, 16'h1300);
		// delta stalls; the low one lands in a first phase
		cfg.absoluteThreshold = 4'h0;
		cfg.deltaThreshold = 4'h1;
		host.goto(16'h2100);
		samp(8'hff);
		chk("hi", flags[4:0], 5'b11001);
		host.read();
		host.goto(16'h2200);
		mot.firstPhase = 1'b1;
		samp(8'h00);
		chk("lo", flags[4:0], 5'b11010);
		waitfor(1'b1);
		$display("test stall done");
		// warning flag alone, a finished move, then the arming delay after top speed
		host.read();
		mot.firstPhase = 1'b0;
		faultPins.thermalWarning = 1'b1;
		idle(6);
		chk("warn", flags[9], 1'b1);
		chk("warnrun", bridgeHiZ, 1'b0);
		faultPins.thermalWarning = 1'b0;
		idle(6);
		chk("warnkeep", flags[9], 1'b1);
		host.read();
		chk("warnclr", flags[9], 1'b0);
		chk("move", holdCurrent, 1'b0);
		mot.motionDone = 1'b1;
		idle(1);
		mot.motionDone = 1'b0;
		chk("done", holdCurrent, 1'b1);
		mot.atMaxVelocity = 1'b0;
		cfg.absoluteThreshold = 4'h2;
		cfg.deltaThreshold = 4'h0;
		cfg.detectStartDelay = 3'h2;
		host.goto(16'h2300);
		mot.atMaxVelocity = 1'b1;
		samp(8'h08);
		chk("early", hardStop, 1'b0);
		repeat (2)
		begin
			mot.fullStep = 1'b1;
			idle(1);
			mot.fullStep = 1'b0;
			idle(1);
		end
		samp(8'h08);
		chk("armed", hardStop, 1'b1);
		$display("test gating done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
